// ---- dv/ctu_top_props.sv ----
// Port-level assertions for the counter and timer unit
`timescale 1ns/1ns
module ctu_top_props
  import ctu_pkg::*;
#(
  parameter int NUM_CNT = ctu_pkg::DEF_NUM_CNT,
  parameter int NUM_TMR = ctu_pkg::DEF_NUM_TMR
) (
  input wire logic                      ref_clk,
  input wire logic                      sys_rst,
  input wire logic [ctu_pkg::IDX_W-1:0] cntIndex,
  input wire ctu_pkg::ctu_wr_t          cntWr,
  input wire logic                      cntSwClearCmd,
  input wire ctu_pkg::ctu_cnt_t         cntRd,
  input wire logic [NUM_CNT-1:0]        cntDoneEvent,
  input wire logic [ctu_pkg::IDX_W-1:0] tmrIndex,
  input wire ctu_pkg::ctu_wr_t          tmrWr,
  input wire logic                      tmrSwClearCmd,
  input wire ctu_pkg::ctu_tmr_t         tmrRd,
  input wire logic [NUM_TMR-1:0]        tmrPulse
);
  // ******************************************************
  // Helpers
  // ******************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Clocks into the present microsecond of the timer 0 pulse; wraps so long pulses never overflow
  logic [15:0] hiLen;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !tmrPulse[0]) begin
      hiLen <= 16'h0;
    end else if (hiLen == 16'(US_CYCLES)) begin
      hiLen <= 16'h1;
    end else begin
      hiLen <= hiLen + 16'h1;
    end
  end

  // Readback lags two clocks, so the index must hold meanwhile
  sequence s_wr(en, fld, f, idx, num);
    en && fld == f && idx < num ##1 idx == $past(idx) && !en;
  endsequence
  sequence s_clr(cmd, idx, num, en);
    cmd && idx < num ##1 idx == $past(idx) && !cmd && !en;
  endsequence

  // ******************************************************
  // Properties
  // ******************************************************
  property p_rst_zero;
    $fell(sys_rst) |-> cntRd == '0 && tmrRd == '0 && cntDoneEvent == '0 && tmrPulse == '0;
  endproperty
  property p_cnt_clr;
    s_clr(cntSwClearCmd, cntIndex, NUM_CNT, cntWr.en) ##0 cntRd.cfg.incSrc == SRC_OFF && cntRd.cfg.clrSrc == SRC_OFF
      |=> cntRd.count == 32'h0 && cntRd.captured == $past(cntRd.count) && cntRd.state == CST_ACTIVE;
  endproperty
  property p_tmr_clr;
    s_clr(tmrSwClearCmd, tmrIndex, NUM_TMR, tmrWr.en)
      |=> tmrRd.elapsedUs == 32'h0 && tmrRd.state inside {TST_DELAY, TST_ACTIVE, TST_DONE};
  endproperty
  property p_cnt_term;
    s_wr(cntWr.en, cntWr.field, FLD_TERMINAL, cntIndex, NUM_CNT) |=> cntRd.cfg.terminal == $past(cntWr.data, 2);
  endproperty
  property p_tmr_delay;
    s_wr(tmrWr.en, tmrWr.field, FLD_DELAY, tmrIndex, NUM_TMR) |=> tmrRd.cfg.delayUs == $past(tmrWr.data, 2);
  endproperty
  property p_cnt_oor;
    cntIndex >= NUM_CNT |=> cntRd == '0;
  endproperty
  property p_cnt_done;
    cntDoneEvent[0] && cntIndex == 4'h0 |=> cntRd.state == CST_DONE && cntRd.count == cntRd.cfg.terminal;
  endproperty
  property p_pulse_state;
    $past(tmrIndex) == 4'h0 |-> (tmrRd.state == TST_ACTIVE) == $past(tmrPulse[0]);
  endproperty
  property p_pulse_len;
    $fell(tmrPulse[0]) |-> hiLen == 16'(US_CYCLES);
  endproperty

  a_rst_zero: assert property (p_rst_zero) else $error("outputs not cleared by reset");
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter software clear wrong");
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer software clear wrong");
  a_cnt_term: assert property (p_cnt_term) else $error("terminal count readback wrong");
  a_tmr_delay: assert property (p_tmr_delay) else $error("timer delay readback wrong");
  a_cnt_oor: assert property (p_cnt_oor) else $error("absent counter reads nonzero");
  a_cnt_done: assert property (p_cnt_done) else $error("done event without terminal count");
  a_pulse_state: assert property (p_pulse_state) else $error("pulse differs from timer state");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse not whole microseconds");
endmodule

// ---- dv/test_ctu_top.sv ----
// Self-checking bench for the counter and timer unit
`timescale 1ns/1ns
module test_ctu_top;
  import ctu_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  logic        cntSwClearCmd;
  logic        tmrSwClearCmd;
  logic [3:0]  extSrc;
  logic [3:0]  cntIndex;
  logic [3:0]  tmrIndex;
  logic [3:0]  cntDoneEvent;
  logic [3:0]  tmrPulse;
  ctu_wr_t     cntWr;
  ctu_wr_t     tmrWr;
  ctu_cnt_t    cntRd;
  ctu_tmr_t    tmrRd;
  ctu_ccfg_t   ec;
  logic [31:0] seed;
  logic [31:0] v;
  logic [31:0] prevCnt;
  int          num_errors;
  int          check_count;
  int          doneCnt;
  int          n;
  int          d;
  int          p;
  int          w;
  ctu_act_e    modes [5] = '{ACT_LOW, ACT_RISE, ACT_FALL, ACT_ANY, ACT_HIGH};

  ctu_top #(.NUM_CNT(4), .NUM_TMR(4), .NUM_EXT(4)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .extSrc(extSrc), .cntIndex(cntIndex), .cntWr(cntWr),
    .cntSwClearCmd(cntSwClearCmd), .cntRd(cntRd), .cntDoneEvent(cntDoneEvent), .tmrIndex(tmrIndex),
    .tmrWr(tmrWr), .tmrSwClearCmd(tmrSwClearCmd), .tmrRd(tmrRd), .tmrPulse(tmrPulse)
  );

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_cnt(ctu_act_e m, int k);
    case (m)
      ACT_RISE, ACT_FALL: return 32'(k);
      ACT_ANY:            return 32'(2 * k);
      default:            return 32'(3 * k);
    endcase
  endfunction

  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wr(logic tmr, ctu_fld_e f, logic [31:0] dat);
    @(negedge ref_clk);
    if (tmr) tmrWr = '{1'b1, f, dat};
    else cntWr = '{1'b1, f, dat};
    @(negedge ref_clk);
    cntWr.en = 1'b0;
    tmrWr.en = 1'b0;
  endtask

  task automatic clr(logic tmr);
    @(negedge ref_clk);
    if (tmr) tmrSwClearCmd = 1'b1;
    else cntSwClearCmd = 1'b1;
    @(negedge ref_clk);
    cntSwClearCmd = 1'b0;
    tmrSwClearCmd = 1'b0;
  endtask

  // Each pulse leaves the idle level for three clocks
  task automatic pulse(int b, int k);
    repeat (k) begin
      extSrc[b] = ~extSrc[b];
      cyc(3);
      extSrc[b] = ~extSrc[b];
      cyc(3);
    end
  endtask

  // Start may land anywhere in the first microsecond
  task automatic run_tmr(int extra);
    w = 0;
    while (!tmrPulse[0] && w < 1000) begin
      cyc(1);
      w++;
    end
    chk("delay", 1, 64'(w >= (d - 1) * US_CYCLES && w <= d * US_CYCLES + extra));
    w = 0;
    while (tmrPulse[0] && w < 1000) begin
      cyc(1);
      w++;
    end
    chk("pulse", 64'(p * US_CYCLES), 64'(w));
    cyc(3);
    chk("elapsed", 64'(d + p), tmrRd.elapsedUs);
    chk("tstate", TST_DONE, tmrRd.state);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ******************************************************
  // Stimulus
  // ******************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (cntDoneEvent[0]) doneCnt++;

  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    {sys_rst, cntSwClearCmd, tmrSwClearCmd, extSrc, cntIndex, tmrIndex} = 15'h4000;
    {cntWr, tmrWr} = '0;
    seed = 32'h1180;
    cyc(12);
    sys_rst = 1'b0;
    cyc(2);
    chk("cstate", CST_IDLE, cntRd.state);
    chk("tstate", TST_IDLE, tmrRd.state);
    $display("test reset done");
    // Random settings on counter 3 only
    cntIndex = 4'h3;
    ec = '{4'(rnd()), ctu_act_e'(rnd() % 5), 4'(rnd()), ctu_act_e'(rnd() % 5), 4'(rnd()), ctu_act_e'(rnd() % 5), rnd()};
    wr(0, FLD_INC_SRC, 32'(ec.incSrc));
    wr(0, FLD_INC_EDGE, 32'(ec.incEdge));
    wr(0, FLD_CLR_SRC, 32'(ec.clrSrc));
    wr(0, FLD_CLR_EDGE, 32'(ec.clrEdge));
    wr(0, FLD_START_SRC, 32'(ec.startSrc));
    wr(0, FLD_START_EDGE, 32'(ec.startEdge));
    wr(0, FLD_TERMINAL, ec.terminal);
    cyc(3);
    chk("cfg3", 64'(ec), 64'(cntRd.cfg));
    cntIndex = 4'h0;
    cyc(3);
    chk("cfg0", 64'(CCFG_RST), 64'(cntRd.cfg));
    cntIndex = 4'(4 + rnd() % 12);
    cyc(3);
    chk("absent", 0, {cntRd.count, cntRd.captured});
    $display("test config done");
    cntIndex = 4'h2;
    v = rnd();
    wr(0, FLD_VALUE, v);
    cyc(3);
    chk("value", v, cntRd.count);
    clr(0);
    cyc(3);
    chk("swclr", {32'h0, v}, {cntRd.count, cntRd.captured});
    chk("cstate", CST_ACTIVE, cntRd.state);
    $display("test value done");
    cntIndex = 4'h0;
    prevCnt = 32'h0;
    wr(0, FLD_INC_SRC, 32'h1);
    foreach (modes[m]) begin
      wr(0, FLD_INC_EDGE, 32'(modes[m]));
      extSrc[0] = (modes[m] == ACT_LOW);
      cyc(4);
      clr(0);
      cyc(3);
      chk("captured", prevCnt, cntRd.captured);
      n = 1 + rnd() % 8;
      pulse(0, n);
      cyc(4);
      prevCnt = exp_cnt(modes[m], n);
      chk("count", prevCnt, cntRd.count);
    end
    $display("test modes done");
    wr(0, FLD_INC_EDGE, 32'(ACT_RISE));
    n = 2 + rnd() % 5;
    wr(0, FLD_TERMINAL, 32'(n));
    clr(0);
    doneCnt = 0;
    pulse(0, n + 1);
    cyc(4);
    chk("done", {32'h1, 32'(n)}, {32'(doneCnt), cntRd.count});
    chk("cstate", CST_DONE, cntRd.state);
    wr(0, FLD_CLR_SRC, 32'h2);
    wr(0, FLD_CLR_EDGE, 32'(ACT_FALL));
    extSrc[1] = 1'b1;
    cyc(4);
    chk("norise", n, cntRd.count);
    extSrc[1] = 1'b0;
    cyc(4);
    chk("clrsrc", {32'h0, 32'(n)}, {cntRd.count, cntRd.captured});
    $display("test terminal done");
    cntIndex = 4'h1;
    wr(0, FLD_INC_SRC, 32'h1);
    wr(0, FLD_START_EDGE, 32'(ACT_HIGH));
    wr(0, FLD_START_SRC, 32'h3);
    pulse(0, 2);
    cyc(2);
    chk("wait", {CST_WAIT, 32'h0}, {cntRd.state, cntRd.count});
    extSrc[2] = 1'b1;
    cyc(4);
    n = 1 + rnd() % 8;
    pulse(0, n);
    cyc(4);
    chk("start", {CST_ACTIVE, 32'(n)}, {cntRd.state, cntRd.count});
    $display("test start done");
    d = 1 + rnd() % 3;
    p = 1 + rnd() % 3;
    wr(1, FLD_DELAY, d);
    wr(1, FLD_PULSE, p);
    clr(1);
    run_tmr(3);
    wr(1, FLD_START_EDGE, 32'(ACT_FALL));
    wr(1, FLD_START_SRC, 32'h4);
    extSrc[3] = 1'b1;
    cyc(5);
    chk("tnorise", TST_DONE, tmrRd.state);
    extSrc[3] = 1'b0;
    run_tmr(7);
    tmrIndex = 4'h2;
    wr(1, FLD_PULSE, 32'h1);
    clr(1);
    cyc(1);
    chk("nodelay", {TST_ACTIVE, 1'b1}, {tmrRd.state, tmrPulse[2]});
    tmrIndex = 4'h1;
    v = rnd();
    wr(1, FLD_VALUE, v);
    cyc(3);
    chk("tvalue", v, tmrRd.elapsedUs);
    tmrIndex = 4'(4 + rnd() % 12);
    cyc(3);
    chk("tabsent", 0, tmrRd.elapsedUs);
    $display("test timer done");
    end_sim();
  end
endmodule

bind ctu_top ctu_top_props #(.NUM_CNT(NUM_CNT), .NUM_TMR(NUM_TMR)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cntIndex(cntIndex), .cntWr(cntWr), .cntSwClearCmd(cntSwClearCmd),
  .cntRd(cntRd), .cntDoneEvent(cntDoneEvent), .tmrIndex(tmrIndex), .tmrWr(tmrWr),
  .tmrSwClearCmd(tmrSwClearCmd), .tmrRd(tmrRd), .tmrPulse(tmrPulse)
);

// ---- logic/ctu_act.sv ----
// Activation qualifier: picks one source and applies the edge or level mode
`timescale 1ns/1ns
module ctu_act (
  input  wire logic [ctu_pkg::SRC_MAX-1:0] srcNow,
  input  wire logic [ctu_pkg::SRC_MAX-1:0] srcPrev,
  input  wire logic [ctu_pkg::SEL_W-1:0]   sel,
  input  wire ctu_pkg::ctu_act_e           mode,
  output logic                             hit
);
  import ctu_pkg::*;

  logic now;
  logic prev;

  assign now  = srcNow[sel];
  assign prev = srcPrev[sel];

  // Source zero is a constant low and low mode is masked off it, so an unselected source never hits
  always_comb begin
    case (mode)
      ACT_RISE: hit = now & ~prev;
      ACT_FALL: hit = ~now & prev;
      ACT_ANY:  hit = now ^ prev;
      ACT_HIGH: hit = now;
      ACT_LOW:  hit = ~now & (sel != SRC_OFF);
      default:  hit = 1'b0;
    endcase
  end
endmodule

// ---- logic/ctu_pkg.sv ----
// Shared types and constants of the counter and timer unit
package ctu_pkg;

  // ******************************************************
  // Widths and defaults
  // ******************************************************
  localparam int SEL_W       = 4;
  localparam int SRC_MAX     = 16;
  localparam int IDX_W       = 4;
  localparam int DATA_W      = 32;
  localparam int DEF_NUM_CNT = 4;
  localparam int DEF_NUM_TMR = 4;
  localparam int DEF_NUM_EXT = 4;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_DIV_W      = $clog2(US_CYCLES);
  localparam logic [US_DIV_W-1:0] US_LAST = US_DIV_W'(US_CYCLES - 1);

  // ******************************************************
  // Encodings
  // ******************************************************
  localparam logic [SEL_W-1:0] SRC_OFF = 4'h0;

  typedef enum logic [2:0] {
    ACT_RISE = 3'h0,
    ACT_FALL = 3'h1,
    ACT_ANY  = 3'h2,
    ACT_HIGH = 3'h3,
    ACT_LOW  = 3'h4
  } ctu_act_e;

  typedef enum logic [3:0] {
    FLD_INC_SRC    = 4'h0,
    FLD_INC_EDGE   = 4'h1,
    FLD_CLR_SRC    = 4'h2,
    FLD_CLR_EDGE   = 4'h3,
    FLD_START_SRC  = 4'h4,
    FLD_START_EDGE = 4'h5,
    FLD_TERMINAL   = 4'h6,
    FLD_VALUE      = 4'h7,
    FLD_DELAY      = 4'h8,
    FLD_PULSE      = 4'h9
  } ctu_fld_e;

  typedef enum logic [3:0] {
    CST_IDLE   = 4'h1,
    CST_WAIT   = 4'h2,
    CST_ACTIVE = 4'h4,
    CST_DONE   = 4'h8
  } ctu_cst_e;

  typedef enum logic [4:0] {
    TST_IDLE   = 5'h01,
    TST_WAIT   = 5'h02,
    TST_DELAY  = 5'h04,
    TST_ACTIVE = 5'h08,
    TST_DONE   = 5'h10
  } ctu_tst_e;

  // ******************************************************
  // Carriers
  // ******************************************************
  typedef struct packed {
    logic [SEL_W-1:0]  incSrc;
    ctu_act_e          incEdge;
    logic [SEL_W-1:0]  clrSrc;
    ctu_act_e          clrEdge;
    logic [SEL_W-1:0]  startSrc;
    ctu_act_e          startEdge;
    logic [DATA_W-1:0] terminal;
  } ctu_ccfg_t;

  typedef struct packed {
    ctu_ccfg_t         cfg;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] captured;
    ctu_cst_e          state;
    logic              done;
  } ctu_cnt_t;

  typedef struct packed {
    logic [SEL_W-1:0]  startSrc;
    ctu_act_e          startEdge;
    logic [DATA_W-1:0] delayUs;
    logic [DATA_W-1:0] pulseUs;
  } ctu_tcfg_t;

  typedef struct packed {
    ctu_tcfg_t         cfg;
    logic [DATA_W-1:0] elapsedUs;
    ctu_tst_e          state;
  } ctu_tmr_t;

  typedef struct packed {
    logic              en;
    ctu_fld_e          field;
    logic [DATA_W-1:0] data;
  } ctu_wr_t;

  localparam ctu_ccfg_t CCFG_RST = '{SRC_OFF, ACT_RISE, SRC_OFF, ACT_RISE, SRC_OFF, ACT_RISE, 32'h0};
  localparam ctu_tcfg_t TCFG_RST = '{SRC_OFF, ACT_RISE, 32'h0, 32'h0};

endpackage

// ---- logic/ctu_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module ctu_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ctu_sync_t;

  ctu_sync_t cur;
  ctu_sync_t nxt;

  always_comb begin
    nxt.meta   = d;
    nxt.stable = cur.meta;
    if (sys_rst) begin
      nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    cur <= nxt;
  end

  assign q = cur.stable;
endmodule

// ---- logic/ctu_top.sv ----
// Bank of selectable event counters and microsecond pulse timers
//
// Operation
// - Counter index picks which counter every setting access touches.
// - A counter increments on its chosen event source.
// - The event source is qualified by edge or level mode.
// - A counter clears when its chosen clear source activates.
// - The clear source has its own activation mode.
// - Software clear command zeroes the chosen counter and sets it running.
// - Present count is readable and loadable by software.
// - Every counter clear captures the count held just before it.
// - Counter raises a done event after its terminal number of events.
// - Chosen counter's state is readable as an enumerated status.
// - A counter with a start source set waits until that source activates or a software clear starts it.
// - Counter start has an activation mode independent of the others.
// - Timer index picks which timer every setting access touches.
// - Timer pulse lasts its programmed length in microseconds.
// - Timer waits its programmed delay in microseconds before the pulse.
// - Software clear command zeroes the chosen timer and starts it.
// - Elapsed microseconds are readable and loadable by software.
// - Chosen timer's state is readable as an enumerated status.
// - A timer starts on its chosen trigger source.
// - Timer trigger is qualified by an activation mode.
`timescale 1ns/1ns
module ctu_top #(
  parameter int NUM_CNT = ctu_pkg::DEF_NUM_CNT,
  parameter int NUM_TMR = ctu_pkg::DEF_NUM_TMR,
  parameter int NUM_EXT = ctu_pkg::DEF_NUM_EXT
) (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [NUM_EXT-1:0]        extSrc,
  input  wire logic [ctu_pkg::IDX_W-1:0] cntIndex,
  input  wire ctu_pkg::ctu_wr_t          cntWr,
  input  wire logic                      cntSwClearCmd,
  output ctu_pkg::ctu_cnt_t              cntRd,
  output logic [NUM_CNT-1:0]             cntDoneEvent,
  input  wire logic [ctu_pkg::IDX_W-1:0] tmrIndex,
  input  wire ctu_pkg::ctu_wr_t          tmrWr,
  input  wire logic                      tmrSwClearCmd,
  output ctu_pkg::ctu_tmr_t              tmrRd,
  output logic [NUM_TMR-1:0]             tmrPulse
);
  import ctu_pkg::*;

  // ******************************************************
  // Parameter checks
  // ******************************************************
  generate
    if (NUM_CNT < 1 || NUM_TMR < 1 || NUM_EXT < 1) begin : gBadCount
      $error("ctu_top needs at least one counter, timer and input");
    end
    if (NUM_EXT + NUM_CNT + NUM_TMR + 1 > SRC_MAX) begin : gBadSrc
      $error("ctu_top has more sources than the selector can address");
    end
    if (NUM_CNT > 2 ** IDX_W || NUM_TMR > 2 ** IDX_W) begin : gBadIdx
      $error("ctu_top has more instances than the index can address");
    end
  endgenerate

  localparam logic [IDX_W-1:0] CNT_LAST = IDX_W'(NUM_CNT - 1);
  localparam logic [IDX_W-1:0] TMR_LAST = IDX_W'(NUM_TMR - 1);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    ctu_cnt_t [NUM_CNT-1:0] cnt;
    ctu_tmr_t [NUM_TMR-1:0] tmr;
    logic [SRC_MAX-1:0]     prev;
    logic [US_DIV_W-1:0]    usDiv;
    logic                   usTick;
    ctu_cnt_t               cntRd;
    ctu_tmr_t               tmrRd;
  } ctu_core_t;

  ctu_core_t cur;
  ctu_core_t nxt;

  logic [NUM_EXT-1:0] extSync;
  logic [SRC_MAX-1:0] srcNow;
  logic [NUM_CNT-1:0] cntDone;
  logic [NUM_TMR-1:0] tmrAct;
  logic [NUM_CNT-1:0] incHit;
  logic [NUM_CNT-1:0] clrHit;
  logic [NUM_CNT-1:0] startHit;
  logic [NUM_TMR-1:0] trigHit;

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic isSel(input logic [IDX_W-1:0] idx, input int unsigned n);
    return idx == IDX_W'(n);
  endfunction

  // Zero delay skips straight to the pulse, zero length skips the pulse
  function automatic ctu_tst_e launch(input ctu_tcfg_t cfg);
    if (cfg.delayUs != '0) begin
      return TST_DELAY;
    end
    if (cfg.pulseUs != '0) begin
      return TST_ACTIVE;
    end
    return TST_DONE;
  endfunction

  // ******************************************************
  // Sources and qualifiers
  // ******************************************************
  ctu_sync #(
    .W (NUM_EXT)
  ) uSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       (extSrc),
    .q       (extSync)
  );

  // Bit zero is the off source; done events and pulses feed back as sources
  assign srcNow = SRC_MAX'({tmrAct, cntDone, extSync, 1'b0});

  generate
    for (genvar i = 0; i < NUM_CNT; i++) begin : gCnt
      assign cntDone[i] = cur.cnt[i].done;
      ctu_act uInc (
        .srcNow  (srcNow),
        .srcPrev (cur.prev),
        .sel     (cur.cnt[i].cfg.incSrc),
        .mode    (cur.cnt[i].cfg.incEdge),
        .hit     (incHit[i])
      );
      ctu_act uClr (
        .srcNow  (srcNow),
        .srcPrev (cur.prev),
        .sel     (cur.cnt[i].cfg.clrSrc),
        .mode    (cur.cnt[i].cfg.clrEdge),
        .hit     (clrHit[i])
      );
      ctu_act uStart (
        .srcNow  (srcNow),
        .srcPrev (cur.prev),
        .sel     (cur.cnt[i].cfg.startSrc),
        .mode    (cur.cnt[i].cfg.startEdge),
        .hit     (startHit[i])
      );
    end
    for (genvar j = 0; j < NUM_TMR; j++) begin : gTmr
      assign tmrAct[j] = cur.tmr[j].state == TST_ACTIVE;
      ctu_act uTrig (
        .srcNow  (srcNow),
        .srcPrev (cur.prev),
        .sel     (cur.tmr[j].cfg.startSrc),
        .mode    (cur.tmr[j].cfg.startEdge),
        .hit     (trigHit[j])
      );
    end
  endgenerate

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    ctu_cnt_t          c;
    ctu_tmr_t          t;
    logic [DATA_W:0]   endUs;
    c     = '0;
    t     = '0;
    endUs = '0;
    nxt   = cur;
    nxt.prev = srcNow;

    if (cur.usDiv == US_LAST) begin
      nxt.usDiv  = '0;
      nxt.usTick = 1'b1;
    end else begin
      nxt.usDiv  = cur.usDiv + 1'b1;
      nxt.usTick = 1'b0;
    end

    for (int i = 0; i < NUM_CNT; i++) begin
      c      = cur.cnt[i];
      c.done = 1'b0;
      if (c.state == CST_WAIT && startHit[i]) begin
        c.state = CST_ACTIVE;
      end
      // count while active; a clear or a load in the same clock wins
      if (c.state == CST_ACTIVE && incHit[i] && !clrHit[i] &&
          !(isSel(cntIndex, i) && (cntSwClearCmd || (cntWr.en && cntWr.field == FLD_VALUE)))) begin
        c.count = c.count + 1'b1;
        if (c.cfg.terminal != '0 && c.count == c.cfg.terminal) begin
          c.done  = 1'b1;
          c.state = CST_DONE;
        end
      end
      if (cntWr.en && isSel(cntIndex, i)) begin
        case (cntWr.field)
          FLD_INC_SRC: begin
            c.cfg.incSrc = cntWr.data[SEL_W-1:0];
          end
          FLD_INC_EDGE: begin
            c.cfg.incEdge = ctu_act_e'(cntWr.data[2:0]);
          end
          FLD_CLR_SRC: begin
            c.cfg.clrSrc = cntWr.data[SEL_W-1:0];
          end
          FLD_CLR_EDGE: begin
            c.cfg.clrEdge = ctu_act_e'(cntWr.data[2:0]);
          end
          FLD_START_SRC: begin
            c.cfg.startSrc = cntWr.data[SEL_W-1:0];
            if (c.state == CST_IDLE && cntWr.data[SEL_W-1:0] != SRC_OFF) begin
              c.state = CST_WAIT;
            end
          end
          FLD_START_EDGE: begin
            c.cfg.startEdge = ctu_act_e'(cntWr.data[2:0]);
          end
          FLD_TERMINAL: begin
            c.cfg.terminal = cntWr.data;
          end
          FLD_VALUE: begin
            c.count = cntWr.data;
          end
          default: begin
            c.count = c.count;
          end
        endcase
      end
      if (clrHit[i]) begin
        c.captured = cur.cnt[i].count;
        c.count    = '0;
        if (c.state == CST_DONE) begin
          c.state = (c.cfg.startSrc != SRC_OFF) ? CST_WAIT : CST_ACTIVE;
        end
      end
      if (cntSwClearCmd && isSel(cntIndex, i)) begin
        c.captured = cur.cnt[i].count;
        c.count    = '0;
        c.state    = CST_ACTIVE;
      end
      nxt.cnt[i] = c;
    end

    for (int j = 0; j < NUM_TMR; j++) begin
      t     = cur.tmr[j];
      endUs = {1'b0, t.cfg.delayUs} + {1'b0, t.cfg.pulseUs};
      if (cur.usTick) begin
        case (t.state)
          TST_DELAY: begin
            t.elapsedUs = t.elapsedUs + 1'b1;
            if (t.elapsedUs >= t.cfg.delayUs) begin
              t.state = (t.cfg.pulseUs != '0) ? TST_ACTIVE : TST_DONE;
            end
          end
          TST_ACTIVE: begin
            t.elapsedUs = t.elapsedUs + 1'b1;
            if ({1'b0, t.elapsedUs} >= endUs) begin
              t.state = TST_DONE;
            end
          end
          default: begin
            t.elapsedUs = t.elapsedUs;
          end
        endcase
      end
      if ((t.state == TST_WAIT || t.state == TST_DONE) && trigHit[j]) begin
        t.elapsedUs = '0;
        t.state     = launch(t.cfg);
      end
      if (tmrWr.en && isSel(tmrIndex, j)) begin
        case (tmrWr.field)
          FLD_START_SRC: begin
            t.cfg.startSrc = tmrWr.data[SEL_W-1:0];
            if (t.state == TST_IDLE && tmrWr.data[SEL_W-1:0] != SRC_OFF) begin
              t.state = TST_WAIT;
            end
          end
          FLD_START_EDGE: begin
            t.cfg.startEdge = ctu_act_e'(tmrWr.data[2:0]);
          end
          FLD_DELAY: begin
            t.cfg.delayUs = tmrWr.data;
          end
          FLD_PULSE: begin
            t.cfg.pulseUs = tmrWr.data;
          end
          FLD_VALUE: begin
            t.elapsedUs = tmrWr.data;
          end
          default: begin
            t.elapsedUs = t.elapsedUs;
          end
        endcase
      end
      if (tmrSwClearCmd && isSel(tmrIndex, j)) begin
        t.elapsedUs = '0;
        t.state     = launch(t.cfg);
      end
      nxt.tmr[j] = t;
    end

    nxt.cntRd = (cntIndex <= CNT_LAST) ? cur.cnt[cntIndex] : '0;
    nxt.tmrRd = (tmrIndex <= TMR_LAST) ? cur.tmr[tmrIndex] : '0;

    if (sys_rst) begin
      nxt = '0;
      for (int i = 0; i < NUM_CNT; i++) begin
        nxt.cnt[i].cfg   = CCFG_RST;
        nxt.cnt[i].state = CST_IDLE;
      end
      for (int j = 0; j < NUM_TMR; j++) begin
        nxt.tmr[j].cfg   = TCFG_RST;
        nxt.tmr[j].state = TST_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    cur <= nxt;
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  // Readback lags the index by one clock; software must allow for that
  assign cntRd        = cur.cntRd;
  assign tmrRd        = cur.tmrRd;
  assign cntDoneEvent = cntDone;
  assign tmrPulse     = tmrAct;
endmodule
